// *** verilog/msc_cmd_handler.sv ***
// modem system command handler: settings, fault gating and tx-if control
//
// Design decisions made here: the plain strobed port and the register addresses.
`default_nettype none
module msc_cmd_handler (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData_r,
   // option strap and interface signals
   input wire logic asyncFitted,
   input wire logic [7:0] ifSigIn,
   output logic [7:0] ifSigOut_r,
   // fault conditions
   input wire logic [7:0] txFaultIn,
   input wire logic [7:0] rxFaultIn,
   input wire logic modMajorFault,
   output logic [7:0] txFaultRep_r,
   output logic [7:0] rxFaultRep_r,
   // transmit if control
   input wire logic rtsIn,
   output logic txIfEn_r,
   // status
   output logic remoteMode_r,
   output logic irq_r
);
   msc_pkg::msc_cfg_s cfg_r, cfg_nxt;
   msc_pkg::msc_time_s time_r, time_nxt;
   msc_pkg::msc_date_s date_r, date_nxt;
   msc_pkg::msc_resp_s resp_r, resp_nxt;
   logic [15:0] faultLog_r, faultLog_nxt;
   logic [msc_pkg::IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic [7:0] devAddr_r, devAddr_nxt;
   logic [31:0] rdData_nxt;
   logic [7:0] sigOut_nxt, txRep_nxt, rxRep_nxt;
   logic txIf_nxt, irq_nxt;
   logic cmdWr, isQuery, opKnown, opAllowed, argOk, accept, reject;
   logic clearLog, newFault;
   logic [3:0] op;
   logic [15:0] arg, value;
   msc_pkg::msc_time_s argTime;
   msc_pkg::msc_date_s argDate;

   // command word decode
   assign cmdWr = regWrStb && (regAddr == msc_pkg::OFS_CMD);
   assign op = regWrData[msc_pkg::CMD_OP_MSB:msc_pkg::CMD_OP_LSB];
   assign arg = regWrData[msc_pkg::CMD_ARG_MSB:msc_pkg::CMD_ARG_LSB];
   assign isQuery = regWrData[msc_pkg::CMD_QUERY_BIT];
   assign argTime = msc_pkg::msc_time_s'(arg[10:0]);
   assign argDate = msc_pkg::msc_date_s'(arg);
   // sense opcodes need the async option fitted
   assign opKnown = (op <= msc_pkg::OP_TXIF_PROG) &&
      !((op <= msc_pkg::OP_SENSE_LAST) && !asyncFitted);
   // only the remote command itself is allowed while in local mode
   assign opAllowed = cfg_r.remote || (op == msc_pkg::OP_REMOTE);

   // argument range checks; an out-of-range value is refused whole
   always_comb begin
      argOk = 1'b1;
      if (op == msc_pkg::OP_TIME) begin
         argOk = (argTime.hour >= msc_pkg::HOUR_MIN) &&
            (argTime.hour <= msc_pkg::HOUR_MAX) &&
            (argTime.minute <= msc_pkg::MINUTE_MAX);
      end else if (op == msc_pkg::OP_DATE) begin
         argOk = (argDate.month >= msc_pkg::MONTH_MIN) &&
            (argDate.month <= msc_pkg::MONTH_MAX) &&
            (argDate.day >= msc_pkg::DAY_MIN) &&
            (argDate.day <= msc_pkg::DAY_MAX) &&
            (argDate.year <= msc_pkg::YEAR_MAX);
      end else if (op == msc_pkg::OP_OPMODE) begin
         argOk = (arg[2:0] == msc_pkg::MSC_TX_ONLY) ||
            (arg[2:0] == msc_pkg::MSC_RX_ONLY) ||
            (arg[2:0] == msc_pkg::MSC_DUPLEX);
      end
   end

   // queries never touch settings, so local mode does not refuse them
   assign accept = cmdWr && opKnown &&
      (isQuery || (opAllowed && argOk));
   assign reject = cmdWr && !accept;

   // settings update from an accepted command
   always_comb begin
      cfg_nxt = cfg_r;
      time_nxt = time_r;
      date_nxt = date_r;
      clearLog = 1'b0;
      if (accept && !isQuery) begin
         if (op <= msc_pkg::OP_SENSE_LAST) begin
            cfg_nxt.sense[op[2:0]] = arg[0];
         end else begin
            case (op)
               msc_pkg::OP_TIME: time_nxt = argTime;
               msc_pkg::OP_DATE: date_nxt = argDate;
               msc_pkg::OP_REMOTE: cfg_nxt.remote = 1'b1;
               msc_pkg::OP_CLR_LOG: clearLog = 1'b1;
               msc_pkg::OP_OPMODE: begin
                  cfg_nxt.mode = msc_pkg::msc_mode_e'(arg[2:0]);
               end
               msc_pkg::OP_RTS_GATE: cfg_nxt.rtsGate = arg[0];
               msc_pkg::OP_TXIF_PROG: cfg_nxt.txIfProg = arg[0];
               default: cfg_nxt = cfg_r;
            endcase
         end
      end
   end

   // value echoed in the response, taken after the update
   always_comb begin
      value = 16'h0000;
      if (op <= msc_pkg::OP_SENSE_LAST) begin
         value = {15'h0000, cfg_nxt.sense[op[2:0]]};
      end else begin
         case (op)
            msc_pkg::OP_TIME: value = {5'h00, time_nxt};
            msc_pkg::OP_DATE: value = date_nxt;
            msc_pkg::OP_REMOTE: value = {15'h0000, cfg_nxt.remote};
            msc_pkg::OP_OPMODE: value = {13'h0000, cfg_nxt.mode};
            msc_pkg::OP_RTS_GATE: value = {15'h0000, cfg_nxt.rtsGate};
            msc_pkg::OP_TXIF_PROG: value = {15'h0000, cfg_nxt.txIfProg};
            default: value = 16'h0000;
         endcase
      end
   end

   // response word; a refused command echoes opcode with no value
   always_comb begin
      resp_nxt = resp_r;
      if (cmdWr) begin
         resp_nxt.devAddr = devAddr_r;
         resp_nxt.opcode = op;
         resp_nxt.reject = reject;
         resp_nxt.query = isQuery;
         resp_nxt.valid = 1'b1;
         resp_nxt.value = accept ? value : 16'h0000;
      end
   end

   // fault gating by operation mode and the fault log
   always_comb begin
      txRep_nxt = txFaultIn &
         {8{cfg_r.mode != msc_pkg::MSC_RX_ONLY}};
      rxRep_nxt = rxFaultIn &
         {8{cfg_r.mode != msc_pkg::MSC_TX_ONLY}};
      newFault = |({rxFaultRep_r, txFaultRep_r} & ~faultLog_r);
      // a fault reported in the clearing cycle stays logged
      faultLog_nxt = (clearLog ? 16'h0000 : faultLog_r) |
         {rxFaultRep_r, txFaultRep_r};
   end

   // tx-if enable; rts only matters while gating is on
   always_comb begin
      txIf_nxt = cfg_r.txIfProg && !modMajorFault &&
         (!cfg_r.rtsGate || rtsIn);
      sigOut_nxt = ifSigIn ^ cfg_r.sense;
   end

   // interrupt status, write one to clear; a new event wins over clear
   always_comb begin
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      devAddr_nxt = devAddr_r;
      if (regWrStb && (regAddr == msc_pkg::OFS_IRQ_STAT)) begin
         stat_nxt = stat_r & ~regWrData[msc_pkg::IRQ_W-1:0];
      end
      if (regWrStb && (regAddr == msc_pkg::OFS_IRQ_MASK)) begin
         mask_nxt = regWrData[msc_pkg::IRQ_W-1:0];
      end
      if (regWrStb && (regAddr == msc_pkg::OFS_DEV_ADDR)) begin
         devAddr_nxt = regWrData[7:0];
      end
      stat_nxt[msc_pkg::IRQ_RESP] = stat_nxt[msc_pkg::IRQ_RESP] | cmdWr;
      stat_nxt[msc_pkg::IRQ_REJECT] = stat_nxt[msc_pkg::IRQ_REJECT] | reject;
      stat_nxt[msc_pkg::IRQ_FAULT] = stat_nxt[msc_pkg::IRQ_FAULT] | newFault;
      irq_nxt = |(stat_r & mask_r);
   end

   // read mux; data stand only in the cycle after the strobe
   always_comb begin
      rdData_nxt = 32'h0000_0000;
      if (regRdStb) begin
         case (regAddr)
            msc_pkg::OFS_RESP: rdData_nxt = 32'(resp_r);
            msc_pkg::OFS_IRQ_STAT: rdData_nxt = 32'(stat_r);
            msc_pkg::OFS_IRQ_MASK: rdData_nxt = 32'(mask_r);
            msc_pkg::OFS_FAULT_LOG: rdData_nxt = 32'(faultLog_r);
            msc_pkg::OFS_CONFIG: rdData_nxt = 32'(cfg_r);
            msc_pkg::OFS_TIMEDATE: rdData_nxt = {5'h00, time_r, date_r};
            msc_pkg::OFS_DEV_ADDR: rdData_nxt = 32'(devAddr_r);
            default: rdData_nxt = 32'h0000_0000;
         endcase
      end
   end

   // all state registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_r <= msc_pkg::CFG_RST;
         time_r <= msc_pkg::TIME_RST;
         date_r <= msc_pkg::DATE_RST;
         resp_r <= '0;
         faultLog_r <= 16'h0000;
         stat_r <= '0;
         mask_r <= '0;
         devAddr_r <= msc_pkg::DEV_ADDR_RST;
         regRdData_r <= 32'h0000_0000;
         ifSigOut_r <= 8'h00;
         txFaultRep_r <= 8'h00;
         rxFaultRep_r <= 8'h00;
         txIfEn_r <= 1'b0;
         remoteMode_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         time_r <= time_nxt;
         date_r <= date_nxt;
         resp_r <= resp_nxt;
         faultLog_r <= faultLog_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         devAddr_r <= devAddr_nxt;
         regRdData_r <= rdData_nxt;
         ifSigOut_r <= sigOut_nxt;
         txFaultRep_r <= txRep_nxt;
         rxFaultRep_r <= rxRep_nxt;
         txIfEn_r <= txIf_nxt;
         remoteMode_r <= cfg_nxt.remote;
         irq_r <= irq_nxt;
      end
   end

   // checks on the handler's own outputs and state
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // rst_n in the antecedent keeps the last reset edge from being judged
   a_sense_applied: assert property (
      rst_n |=> ifSigOut_r == ($past(ifSigIn) ^ $past(cfg_r.sense)))
      else $error("interface sense not applied");
   a_sense_no_async: assert property (
      cmdWr && !isQuery && (op <= msc_pkg::OP_SENSE_LAST) && !asyncFitted
      |=> $stable(cfg_r.sense) ##0 resp_r.reject)
      else $error("sense command taken without async option");
   a_time_legal: assert property (
      (time_r.hour >= msc_pkg::HOUR_MIN) && (time_r.hour <= msc_pkg::HOUR_MAX)
      && (time_r.minute <= msc_pkg::MINUTE_MAX))
      else $error("stored time out of range");
   a_date_legal: assert property (
      (date_r.month >= msc_pkg::MONTH_MIN) &&
      (date_r.month <= msc_pkg::MONTH_MAX) &&
      (date_r.day >= msc_pkg::DAY_MIN) && (date_r.year <= msc_pkg::YEAR_MAX))
      else $error("stored date out of range");
   a_remote_entry: assert property (
      cmdWr && !isQuery && (op == msc_pkg::OP_REMOTE)
      |=> remoteMode_r && !resp_r.reject ##1 stat_r[msc_pkg::IRQ_RESP])
      else $error("remote command not honoured");
   a_query_answer: assert property (
      cmdWr && isQuery && (op >= msc_pkg::OP_TIME) &&
      (op <= msc_pkg::OP_TXIF_PROG) |=> resp_r.valid && !resp_r.reject)
      else $error("status query refused");
   a_local_frozen: assert property (
      !cfg_r.remote && !(cmdWr && (op == msc_pkg::OP_REMOTE))
      |=> $stable(time_r) && $stable(date_r) && $stable(cfg_r))
      else $error("settings changed in local mode");
   a_log_cleared: assert property (
      accept && !isQuery && (op == msc_pkg::OP_CLR_LOG) &&
      (txFaultRep_r == 8'h00) && (rxFaultRep_r == 8'h00)
      |=> faultLog_r == 16'h0000)
      else $error("fault log not erased");
   a_mode_onehot: assert property (
      $onehot(cfg_r.mode))
      else $error("operation mode not one of three");
   a_txonly_norx: assert property (
      cfg_r.mode == msc_pkg::MSC_TX_ONLY |=> rxFaultRep_r == 8'h00)
      else $error("receive fault reported in transmit-only mode");
   a_rxonly_notx: assert property (
      cfg_r.mode == msc_pkg::MSC_RX_ONLY |=> txFaultRep_r == 8'h00)
      else $error("transmit fault reported in receive-only mode");
   a_rts_gates: assert property (
      cfg_r.rtsGate && (!rtsIn || modMajorFault || !cfg_r.txIfProg)
      |=> !txIfEn_r)
      else $error("tx-if on without rts, program or with fault");
   a_rts_ignored: assert property (
      rst_n && !cfg_r.rtsGate && cfg_r.txIfProg && !modMajorFault
      |=> txIfEn_r)
      else $error("tx-if off although rts gating is off");
   a_resp_echo: assert property (
      cmdWr |=> (resp_r.opcode == $past(op)) &&
      (resp_r.devAddr == $past(devAddr_r)) && resp_r.valid)
      else $error("response does not echo command");

   c_remote_config: cover property (
      remoteMode_r ##[1:20] (accept && !isQuery && op == msc_pkg::OP_OPMODE));
   c_local_query: cover property (!cfg_r.remote && accept && isQuery);
   c_local_refused: cover property (!cfg_r.remote && reject);
   c_log_clear: cover property ((faultLog_r != 16'h0000) ##1 clearLog);
endmodule
`default_nettype wire

// *** pkg/msc_pkg.sv ***
// constants, register map and types of the modem system command handler
`default_nettype none
package msc_pkg;
   // register byte offsets on the plain register port
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_RESP = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_FAULT_LOG = 8'h10;
   localparam logic [7:0] OFS_CONFIG = 8'h14;
   localparam logic [7:0] OFS_TIMEDATE = 8'h18;
   localparam logic [7:0] OFS_DEV_ADDR = 8'h1C;

   // command word field positions
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_MSB = 3;
   localparam int CMD_ARG_LSB = 8;
   localparam int CMD_ARG_MSB = 23;
   localparam int CMD_QUERY_BIT = 31;

   // opcodes: 0..7 are the interface-signal sense commands
   localparam logic [3:0] OP_SENSE_LAST = 4'h7;
   localparam logic [3:0] OP_TIME = 4'h8;
   localparam logic [3:0] OP_DATE = 4'h9;
   localparam logic [3:0] OP_REMOTE = 4'hA;
   localparam logic [3:0] OP_CLR_LOG = 4'hB;
   localparam logic [3:0] OP_OPMODE = 4'hC;
   localparam logic [3:0] OP_RTS_GATE = 4'hD;
   localparam logic [3:0] OP_TXIF_PROG = 4'hE;

   // sense encodings
   localparam logic NORMAL_SENSE = 1'b0;
   localparam logic INVERTED_SENSE = 1'b1;

   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_RESP = 0;
   localparam int IRQ_REJECT = 1;
   localparam int IRQ_FAULT = 2;

   // legal ranges of time and date fields
   localparam logic [3:0] HOUR_MIN = 4'h1;
   localparam logic [3:0] HOUR_MAX = 4'hC;
   localparam logic [5:0] MINUTE_MAX = 6'h3B;
   localparam logic [3:0] MONTH_MIN = 4'h1;
   localparam logic [3:0] MONTH_MAX = 4'hC;
   localparam logic [4:0] DAY_MIN = 5'h01;
   localparam logic [4:0] DAY_MAX = 5'h1F;
   localparam logic [6:0] YEAR_MAX = 7'h63;

   typedef enum logic [2:0] {
      MSC_TX_ONLY = 3'b001,
      MSC_RX_ONLY = 3'b010,
      MSC_DUPLEX = 3'b100
   } msc_mode_e;

   typedef struct packed {
      logic remote;
      logic txIfProg;
      logic rtsGate;
      msc_mode_e mode;
      logic [7:0] sense;
   } msc_cfg_s;

   typedef struct packed {
      logic pm;
      logic [5:0] minute;
      logic [3:0] hour;
   } msc_time_s;

   typedef struct packed {
      logic [6:0] year;
      logic [4:0] day;
      logic [3:0] month;
   } msc_date_s;

   typedef struct packed {
      logic [15:0] value;
      logic valid;
      logic query;
      logic reject;
      logic [3:0] opcode;
      logic [7:0] devAddr;
   } msc_resp_s;

   // values after reset
   localparam msc_cfg_s CFG_RST = '{remote: 1'b0, txIfProg: 1'b1,
      rtsGate: 1'b0, mode: MSC_DUPLEX, sense: 8'h00};
   localparam msc_time_s TIME_RST = '{pm: 1'b0, minute: 6'h00, hour: 4'hC};
   localparam msc_date_s DATE_RST = '{year: 7'h00, day: 5'h01,
      month: 4'h1};
   localparam logic [7:0] DEV_ADDR_RST = 8'h01;
endpackage
`default_nettype wire

// *** tb/msc_host_model.sv ***
// host-side model: register port master issuing commands and reads
`default_nettype none
module msc_host_model (
   // clock
   input wire logic core_clk,
   // register port
   output logic [7:0] regAddr,
   output logic [31:0] regWrData,
   output logic regWrStb,
   output logic regRdStb,
   input wire logic [31:0] regRdData_r
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus from time zero
   initial begin
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
   end

   // leading edge keeps a strobe from being set twice in one step
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1;
      d = regRdData_r;
   endtask

   // command word: query flag, argument, opcode
   task automatic sendCmd(input logic [3:0] op, input logic [15:0] arg,
      input logic qry);
      wrReg(msc_pkg::OFS_CMD, {qry, 7'h00, arg, 4'h0, op});
   endtask

   // time argument: am/pm, minute, hour
   function automatic logic [15:0] timeArg(input logic [3:0] h,
      input logic [5:0] m, input logic pm);
      return {5'h00, pm, m, h};
   endfunction

   // date argument: year, day, month
   function automatic logic [15:0] dateArg(input logic [3:0] mo,
      input logic [4:0] d, input logic [6:0] y);
      return {y, d, mo};
   endfunction
endmodule
`default_nettype wire

// *** tb/tb_msc_cmd_handler.sv ***
// self-checking bench of the modem system command handler
`default_nettype none
module tb_msc_cmd_handler;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk;
   logic rst_n;
   logic [7:0] regAddr;
   logic [31:0] regWrData;
   logic regWrStb;
   logic regRdStb;
   logic [31:0] regRdData_r;
   logic asyncFitted;
   logic [7:0] ifSigIn;
   logic [7:0] ifSigOut_r;
   logic [7:0] txFaultIn;
   logic [7:0] rxFaultIn;
   logic modMajorFault;
   logic [7:0] txFaultRep_r;
   logic [7:0] rxFaultRep_r;
   logic rtsIn;
   logic txIfEn_r;
   logic remoteMode_r;
   logic irq_r;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [7:0] devAddr;

   msc_cmd_handler dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData_r(regRdData_r),
      .asyncFitted(asyncFitted), .ifSigIn(ifSigIn),
      .ifSigOut_r(ifSigOut_r), .txFaultIn(txFaultIn),
      .rxFaultIn(rxFaultIn), .modMajorFault(modMajorFault),
      .txFaultRep_r(txFaultRep_r), .rxFaultRep_r(rxFaultRep_r),
      .rtsIn(rtsIn), .txIfEn_r(txIfEn_r), .remoteMode_r(remoteMode_r),
      .irq_r(irq_r));
   msc_host_model host_u (.core_clk(core_clk), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData_r(regRdData_r));

   // 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // hang guard: far above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
      input string what);
      host_u.rdReg(a, rd);
      chk(what, exp, rd);
   endtask

   // level outputs are registered; a few edges let them land
   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // send one command, then read the response word back
   task automatic cmdChk(input logic [3:0] op, input logic [15:0] arg,
      input logic qry, input logic rej, input logic [15:0] val,
      input logic vOk, input string what);
      logic [31:0] exp;
      exp = {1'b0, rej ? 16'h0000 : val, 1'b1, qry, rej, op, devAddr};
      host_u.sendCmd(op, arg, qry);
      host_u.rdReg(msc_pkg::OFS_RESP, rd);
      if (vOk) begin
         chk(what, exp, rd);
      end else begin
         chk(what, {17'h0, exp[14:0]}, {17'h0, rd[14:0]});
      end
   endtask

   task automatic testReset();
      rdChk(msc_pkg::OFS_CONFIG, 32'h0000_1400, "config");
      rdChk(msc_pkg::OFS_TIMEDATE, 32'h000C_0011, "timedate");
      rdChk(msc_pkg::OFS_DEV_ADDR, 32'h0000_0001, "dev addr");
      rdChk(8'h20, 32'h0000_0000, "unmapped");
      chk("tx if", 32'h1, {31'h0, txIfEn_r});
      $display("test reset done");
   endtask

   task automatic testLocal();
      host_u.wrReg(msc_pkg::OFS_DEV_ADDR, 32'h0000_005A);
      devAddr = 8'h5A;
      rdChk(msc_pkg::OFS_DEV_ADDR, 32'h0000_005A, "dev addr w");
      cmdChk(msc_pkg::OP_OPMODE, 16'h1, 0, 1, 0, 1, "local set");
      cmdChk(msc_pkg::OP_CLR_LOG, 16'h0, 0, 1, 0, 1, "local clr");
      rdChk(msc_pkg::OFS_CONFIG, 32'h0000_1400, "cfg kept");
      cmdChk(msc_pkg::OP_TIME, 16'h0, 1, 0, 16'hC, 1, "time q");
      cmdChk(msc_pkg::OP_OPMODE, 16'h0, 1, 0, 16'h4, 1, "mode q");
      cmdChk(4'hF, 16'h0, 1, 1, 0, 1, "bad opcode");
      $display("test local done");
   endtask

   // remote entry, plus interrupt raise, mask and clear
   task automatic testRemote();
      host_u.wrReg(msc_pkg::OFS_IRQ_STAT, 32'h0000_0007);
      cmdChk(msc_pkg::OP_REMOTE, 16'h0, 0, 0, 16'h1, 1, "remote");
      chk("remote mode", 32'h1, {31'h0, remoteMode_r});
      settle();
      chk("irq masked", 32'h0, {31'h0, irq_r});
      host_u.wrReg(msc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      settle();
      chk("irq up", 32'h1, {31'h0, irq_r});
      rdChk(msc_pkg::OFS_IRQ_STAT, 32'h0000_0001, "irq stat");
      host_u.wrReg(msc_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      settle();
      chk("irq clr", 32'h0, {31'h0, irq_r});
      $display("test remote done");
   endtask

   task automatic testSense();
      logic [7:0] sn;
      sn = 8'h00;
      cmdChk(4'h0, 16'h1, 0, 1, 0, 1, "no option");
      @(posedge core_clk);
      asyncFitted <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         cmdChk(4'(i), 16'h1, 0, 0, 16'h1, 1, "sense set");
         sn[i] = 1'b1;
         settle();
         chk("sig out", {24'h0, ifSigIn ^ sn}, {24'h0, ifSigOut_r});
      end
      cmdChk(4'h2, 16'h0, 0, 0, 16'h0, 1, "sense nrm");
      sn[2] = 1'b0;
      settle();
      chk("sig nrm", {24'h0, ifSigIn ^ sn}, {24'h0, ifSigOut_r});
      cmdChk(4'h3, 16'h0, 1, 0, 16'h1, 1, "sense q");
      $display("test sense done");
   endtask

   task automatic testTimeDate();
      logic [15:0] t;
      logic [15:0] d;
      t = host_u.timeArg(4'hB, 6'h3B, 1'b1);
      d = host_u.dateArg(4'hC, 5'h1F, 7'h63);
      cmdChk(msc_pkg::OP_TIME, t, 0, 0, t, 1, "time");
      cmdChk(msc_pkg::OP_TIME, 16'h000D, 0, 1, 0, 1, "hour 13");
      cmdChk(msc_pkg::OP_TIME, 16'h0000, 0, 1, 0, 1, "hour 0");
      cmdChk(msc_pkg::OP_TIME, 16'h03C1, 0, 1, 0, 1, "min 60");
      cmdChk(msc_pkg::OP_DATE, d, 0, 0, d, 1, "date");
      cmdChk(msc_pkg::OP_DATE, 16'h001D, 0, 1, 0, 1, "month 13");
      cmdChk(msc_pkg::OP_DATE, 16'h0001, 0, 1, 0, 1, "day 0");
      cmdChk(msc_pkg::OP_DATE, 16'hC811, 0, 1, 0, 1, "year 100");
      rdChk(msc_pkg::OFS_TIMEDATE, 32'h07BB_C7FC, "td read");
      $display("test time date done");
   endtask

   task automatic testModes();
      logic [2:0] md [3];
      md = '{3'b001, 3'b010, 3'b100};
      @(posedge core_clk);
      txFaultIn <= 8'h3C;
      rxFaultIn <= 8'hC3;
      cmdChk(msc_pkg::OP_OPMODE, 16'h3, 0, 1, 0, 1, "mode bad");
      for (int i = 0; i < 3; i++) begin
         cmdChk(msc_pkg::OP_OPMODE, {13'h0, md[i]}, 0, 0, {13'h0, md[i]},
            1, "mode");
         settle();
         chk("tx rep", md[i][1] ? 32'h0 : 32'h3C, {24'h0, txFaultRep_r});
         chk("rx rep", md[i][0] ? 32'h0 : 32'hC3, {24'h0, rxFaultRep_r});
      end
      $display("test modes done");
   endtask

   task automatic testLog();
      rdChk(msc_pkg::OFS_FAULT_LOG, 32'h0000_C33C, "log full");
      // response, refusal and fault-logged events all seen by now
      rdChk(msc_pkg::OFS_IRQ_STAT, 32'h0000_0007, "irq stat f");
      @(posedge core_clk);
      txFaultIn <= 8'h00;
      rxFaultIn <= 8'h00;
      settle();
      cmdChk(msc_pkg::OP_CLR_LOG, 16'h0, 0, 0, 0, 1, "clr");
      rdChk(msc_pkg::OFS_FAULT_LOG, 32'h0000_0000, "log clr");
      $display("test log done");
   endtask

   task automatic lvl(input logic r, input logic f, input logic exp);
      @(posedge core_clk);
      rtsIn <= r;
      modMajorFault <= f;
      settle();
      chk("tx if", {31'h0, exp}, {31'h0, txIfEn_r});
   endtask

   task automatic testRts();
      lvl(1'b0, 1'b0, 1'b1);
      lvl(1'b1, 1'b1, 1'b0);
      cmdChk(msc_pkg::OP_RTS_GATE, 16'h1, 0, 0, 16'h1, 1, "gate");
      lvl(1'b0, 1'b0, 1'b0);
      lvl(1'b1, 1'b0, 1'b1);
      lvl(1'b1, 1'b1, 1'b0);
      cmdChk(msc_pkg::OP_TXIF_PROG, 16'h0, 0, 0, 0, 1, "prog");
      lvl(1'b1, 1'b0, 1'b0);
      $display("test rts done");
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // reset for 20 cycles, then the scenarios in order
   initial begin
      rst_n = 1'b0;
      asyncFitted = 1'b0;
      ifSigIn = 8'hA5;
      txFaultIn = 8'h00;
      rxFaultIn = 8'h00;
      modMajorFault = 1'b0;
      rtsIn = 1'b0;
      devAddr = msc_pkg::DEV_ADDR_RST;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      settle();
      testReset();
      testLocal();
      testRemote();
      testSense();
      testTimeDate();
      testModes();
      testLog();
      testRts();
      tally_and_finish();
   end
endmodule
`default_nettype wire
